/* scc_pkg.sv */
package scc_pkg;

   localparam int ADDR_W = 2;

   // register word addresses
   localparam logic [1:0] SCC_ADDR_CTL1 = 2'h0;
   localparam logic [1:0] SCC_ADDR_CTL2 = 2'h1;
   localparam logic [1:0] SCC_ADDR_STAT = 2'h2;
   localparam logic [1:0] SCC_ADDR_DATA = 2'h3;

   // serial_control_one fields
   localparam int C1_RXIE = 7;
   localparam int C1_EN   = 6;
   localparam int C1_TXIE = 5;
   localparam int C1_ROLE = 4;
   localparam int C1_CLOCK_POLARITY = 3;
   localparam int C1_CLOCK_PHASE = 2;
   localparam int C1_SELECT_OUTPUT_ENABLE = 1;
   localparam int C1_LSBF = 0;

   // serial_control_two fields
   localparam int C2_FDE = 4;
   localparam int C2_SOE = 3;
   localparam int C2_WST = 1;
   localparam int C2_SWS = 0;

   // status fields
   localparam int ST_RXF = 7;
   localparam int ST_TXE = 5;
   localparam int ST_FLT = 4;

   localparam logic [7:0] CTL1_RST  = 8'h04;
   localparam logic [7:0] CTL2_RST  = 8'h00;
   localparam logic [7:0] CTL2_MASK = 8'h1B;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   // sixteen clock edges make one byte
   localparam logic [4:0] EDGE_LAST = 5'h0F;
   localparam logic [4:0] EDGE_ZERO = 5'h00;
   localparam int HALF_CYCLES_DEF   = 4;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN  = 2'b01,
      ST_DONE = 2'b11
   } scc_state_type;

   typedef struct packed {
      logic sclk;
      logic mosi;
      logic miso;
      logic ss_n;
   } scc_pins_in_type;

   typedef struct packed {
      logic sclk_o;
      logic sclk_oe;
      logic mosi_o;
      logic mosi_oe;
      logic miso_o;
      logic miso_oe;
      logic ss_o;
      logic ss_oe;
   } scc_pins_out_type;

endpackage : scc_pkg

/* scc_spi_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none

module scc_spi_ctrl #(
   parameter int HALF_CYCLES = scc_pkg::HALF_CYCLES_DEF
) (
   input  wire  logic                     clk,
   input  wire  logic                     arst_n,
   input  wire  logic [scc_pkg::ADDR_W-1:0] addr,
   input  wire  logic [7:0]               wr_data,
   input  wire  logic                     wr_stb,
   input  wire  logic                     rd_stb,
   output logic [7:0]                     rd_data,
   input  wire  scc_pkg::scc_pins_in_type pins_in,
   output scc_pkg::scc_pins_out_type      pins_out,
   input  wire  logic                     wait_mode,
   output logic                           irq
);
   import scc_pkg::*;

   function automatic logic [7:0] shift_in(input logic [7:0] s, input logic b, input logic lsb);
      shift_in = lsb ? {b, s[7:1]} : {s[6:0], b};
   endfunction : shift_in

   localparam logic [7:0] HALF_LAST = 8'(HALF_CYCLES - 1);

   logic [7:0]      ctl1_r, ctl2_r, rd_data_r;
   scc_pins_in_type pin_s1_r, pin_s2_r;
   logic            sclk_d_r;
   scc_state_type   state_r;
   logic [4:0]      edge_cnt_r;
   logic [7:0]      div_cnt_r, shift_r, txbuf_r, rxbuf_r;
   logic            sclk_lvl_r, lat_r, txfull_r, rxfull_r, fault_r;
   logic            rx_arm_r, tx_arm_r, flt_arm_r;

   ////////////////////////////////////////////////////////////////////////
   logic en, master, clock_polarity, clock_phase, select_output_enable, lsbf, fde, soe, sws, freeze;
   logic fault_in_mode, ss_auto, slave_sel, edge_p, sample_e, shift_e;
   logic din, dout, rx_full, tx_empty, done_go, m_start, s_start;
   logic stat_rd, data_rd, data_wr, c1_wr;

   assign en     = ctl1_r[C1_EN];
   assign master = ctl1_r[C1_ROLE];
   assign clock_polarity   = ctl1_r[C1_CLOCK_POLARITY];
   assign clock_phase   = ctl1_r[C1_CLOCK_PHASE];
   assign select_output_enable   = ctl1_r[C1_SELECT_OUTPUT_ENABLE];
   assign lsbf   = ctl1_r[C1_LSBF];
   assign fde    = ctl2_r[C2_FDE];
   assign soe    = ctl2_r[C2_SOE];
   assign sws    = ctl2_r[C2_SWS];
   assign freeze = ctl2_r[C2_WST] & wait_mode;

   assign fault_in_mode = en & master & fde & ~select_output_enable;
   assign ss_auto       = en & master & fde & select_output_enable;
   assign slave_sel     = en & ~master & ~pin_s2_r.ss_n;

   assign rx_full  = rxfull_r & en;
   assign tx_empty = ~txfull_r | ~en;

   assign stat_rd = rd_stb & (addr == SCC_ADDR_STAT);
   assign data_rd = rd_stb & (addr == SCC_ADDR_DATA);
   assign data_wr = wr_stb & (addr == SCC_ADDR_DATA);
   assign c1_wr   = wr_stb & (addr == SCC_ADDR_CTL1);

   ////////////////////////////////////////////////////////////////////////
   // register port
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ctl1_r <= CTL1_RST;
         ctl2_r <= CTL2_RST;
      end
      else if (wr_stb)
      begin
         if (addr == SCC_ADDR_CTL1)
            ctl1_r <= wr_data;
         if (addr == SCC_ADDR_CTL2)
            ctl2_r <= wr_data & CTL2_MASK;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         rd_data_r <= BYTE_ZERO;
      else if (rd_stb)
      begin
         unique case (addr)
            SCC_ADDR_CTL1: rd_data_r <= ctl1_r;
            SCC_ADDR_CTL2: rd_data_r <= ctl2_r & CTL2_MASK;
            SCC_ADDR_STAT: rd_data_r <= {rx_full, 1'b0, tx_empty, fault_r, 4'h0};
            SCC_ADDR_DATA: rd_data_r <= rxbuf_r;
         endcase
      end
   end
   assign rd_data = rd_data_r;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers; only the second stage is looked at
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pin_s1_r <= '1;
         pin_s2_r <= '1;
         sclk_d_r <= 1'b1;
      end
      else
      begin
         pin_s1_r <= pins_in;
         pin_s2_r <= pin_s1_r;
         sclk_d_r <= pin_s2_r.sclk;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bit engine
   assign edge_p = (state_r == ST_RUN) &
                   (master ? (div_cnt_r == HALF_LAST) : (pin_s2_r.sclk ^ sclk_d_r));
   assign sample_e = (edge_cnt_r[0] == clock_phase);
   assign shift_e  = ~sample_e & (clock_phase ? (edge_cnt_r != EDGE_ZERO) : (edge_cnt_r != EDGE_LAST));
   assign din  = master ? (sws ? pin_s2_r.mosi : pin_s2_r.miso)
                        : (sws ? pin_s2_r.miso : pin_s2_r.mosi);
   assign dout = lsbf ? shift_r[0] : shift_r[7];
   assign m_start = (state_r == ST_IDLE) & master & txfull_r & ~fault_r;
   assign s_start = (state_r == ST_IDLE) & slave_sel;
   assign done_go = (state_r == ST_DONE) & (~master | (div_cnt_r == HALF_LAST)) & ~freeze;

   // disable aborts and initialises the engine
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_r    <= ST_IDLE;
         edge_cnt_r <= EDGE_ZERO;
         div_cnt_r  <= BYTE_ZERO;
         sclk_lvl_r <= 1'b0;
         shift_r    <= BYTE_ZERO;
         lat_r      <= 1'b0;
      end
      else if (!en || (master && fault_r) || (!master && state_r == ST_RUN && !slave_sel))
      begin
         state_r    <= ST_IDLE;
         edge_cnt_r <= EDGE_ZERO;
         div_cnt_r  <= BYTE_ZERO;
         sclk_lvl_r <= 1'b0;
         if (!en)
            shift_r <= BYTE_ZERO;
      end
      else if (!freeze)
      begin
         unique case (state_r)
            ST_IDLE:
            begin
               div_cnt_r  <= BYTE_ZERO;
               edge_cnt_r <= EDGE_ZERO;
               if (m_start || s_start)
               begin
                  state_r <= ST_RUN;
                  shift_r <= txfull_r ? txbuf_r : BYTE_ZERO;
               end
            end
            ST_RUN:
            begin
               div_cnt_r <= edge_p ? BYTE_ZERO : div_cnt_r + 8'h01;
               if (edge_p)
               begin
                  edge_cnt_r <= edge_cnt_r + 5'h01;
                  sclk_lvl_r <= ~sclk_lvl_r;
                  if (sample_e)
                     lat_r <= din;
                  if (shift_e)
                     shift_r <= shift_in(shift_r, lat_r, lsbf);
                  if (edge_cnt_r == EDGE_LAST)
                     state_r <= ST_DONE;
               end
            end
            ST_DONE:
            begin
               div_cnt_r <= div_cnt_r + 8'h01;
               if (done_go)
                  state_r <= ST_IDLE;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // buffers and flags; a hardware set wins over a software clear
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         txbuf_r  <= BYTE_ZERO;
         txfull_r <= 1'b0;
         tx_arm_r <= 1'b0;
      end
      else if (!en)
      begin
         txbuf_r  <= BYTE_ZERO;
         txfull_r <= 1'b0;
         tx_arm_r <= 1'b0;
      end
      else
      begin
         if (stat_rd && tx_empty)
            tx_arm_r <= 1'b1;
         else if (data_wr)
            tx_arm_r <= 1'b0;
         if (data_wr && tx_arm_r && !txfull_r)
         begin
            txbuf_r  <= wr_data;
            txfull_r <= 1'b1;
         end
         else if ((m_start || s_start) && !freeze && !(master && fault_r))
            txfull_r <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rxbuf_r  <= BYTE_ZERO;
         rxfull_r <= 1'b0;
         rx_arm_r <= 1'b0;
      end
      else if (!en)
      begin
         rxbuf_r  <= BYTE_ZERO;
         rxfull_r <= 1'b0;
         rx_arm_r <= 1'b0;
      end
      else
      begin
         if (stat_rd && rxfull_r)
            rx_arm_r <= 1'b1;
         else if (data_rd)
            rx_arm_r <= 1'b0;
         // a byte arriving while the buffer is still full is dropped
         if (done_go && !rxfull_r)
         begin
            rxbuf_r  <= shift_in(shift_r, lat_r, lsbf);
            rxfull_r <= 1'b1;
         end
         else if (done_go)
            rxfull_r <= 1'b1;
         else if (data_rd && rx_arm_r)
            rxfull_r <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         fault_r   <= 1'b0;
         flt_arm_r <= 1'b0;
      end
      else
      begin
         if (stat_rd && fault_r)
            flt_arm_r <= 1'b1;
         else if (c1_wr)
            flt_arm_r <= 1'b0;
         // fault input low sets the flag
         if (fault_in_mode && !pin_s2_r.ss_n && !freeze)
            fault_r <= 1'b1;
         else if (c1_wr && flt_arm_r)
            fault_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // receive, fault and transmit interrupt
   assign irq = (ctl1_r[C1_RXIE] & (rx_full | fault_r)) | (ctl1_r[C1_TXIE] & tx_empty);

   ////////////////////////////////////////////////////////////////////////
   // pin muxing; every enable is gated by the module enable
   always_comb
   begin
      pins_out = '0;
      pins_out.sclk_o  = clock_polarity ^ sclk_lvl_r;
      pins_out.sclk_oe = en & master;
      pins_out.mosi_o  = dout;
      pins_out.miso_o  = dout;
      // separate pins when single-wire is off
      pins_out.mosi_oe = en & master & (~sws | soe);
      pins_out.miso_oe = en & ~master & slave_sel & (~sws | soe);
      // select pin released without fault detect
      // automatic select output while a byte is moving
      pins_out.ss_o    = (state_r == ST_IDLE);
      pins_out.ss_oe   = ss_auto;
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   irq_rx_a: assert property (ctl1_r[C1_RXIE] && (rx_full || fault_r) |-> irq)
      else $error("receive or fault interrupt missing");
   disable_abort_a: assert property ($fell(en) |=> state_r == ST_IDLE && !rxfull_r && !txfull_r)
      else $error("disable did not abort");
   dis_flags_a: assert property (!en |-> !rx_full && tx_empty)
      else $error("flags not forced while disabled");
   irq_tx_a: assert property (ctl1_r[C1_TXIE] && tx_empty |-> irq)
      else $error("transmit interrupt missing");
   clk_idle_a: assert property (en && master && state_r == ST_IDLE |-> pins_out.sclk_o == clock_polarity)
      else $error("serial clock not at idle level");
   ss_gpio_a: assert property (en && master && !fde |-> !pins_out.ss_oe)
      else $error("select pin not released");
   fault_set_a: assert property (fault_in_mode && !pin_s2_r.ss_n && !freeze |=> fault_r)
      else $error("fault flag not set");
   ss_auto_a: assert property (ss_auto && state_r == ST_RUN |-> pins_out.ss_oe && !pins_out.ss_o)
      else $error("select output not asserted");
   slave_ss_a: assert property (en && !master |-> !pins_out.ss_oe && !pins_out.sclk_oe)
      else $error("slave drives select or clock");
   c2_zero_a: assert property (rd_stb && addr == SCC_ADDR_CTL2 |=> rd_data[7:5] == 3'h0 && !rd_data[2])
      else $error("reserved control bits not zero");
   single_m_a: assert property (en && master && sws |-> !pins_out.miso_oe && pins_out.mosi_oe == soe)
      else $error("single-wire master pin use wrong");
   dual_m_a: assert property (en && master && !sws |-> pins_out.mosi_oe && !pins_out.miso_oe)
      else $error("dual-pin master pin use wrong");
   released_a: assert property (!en |-> pins_out.sclk_oe == 0 && !pins_out.mosi_oe && !pins_out.miso_oe && !pins_out.ss_oe)
      else $error("pins driven while disabled");
   freeze_a: assert property (freeze && en && state_r == ST_RUN && !fault_r && (master || slave_sel) |=> $stable(edge_cnt_r))
      else $error("engine ran during wait stop");
   first_edge_a: assert property (m_start && !freeze && en |=> ##1 (pins_out.sclk_o == clock_polarity) [*2])
      else $error("first clock edge too early");

   master_done_c: cover property (master && done_go);
   slave_done_c: cover property (!master && done_go);
   fault_c: cover property ($rose(fault_r));
   single_c: cover property (sws && done_go);

endmodule : scc_spi_ctrl

`default_nettype wire

/* scc_far_slave.sv */
`timescale 1ns/1ns
`default_nettype none

// far-side peripheral: a plain shift-register slave
module scc_far_slave (
   input  wire logic       sclk,
   input  wire logic       mosi,
   input  wire logic       ss_n,
   input  wire logic       clock_polarity,
   input  wire logic       clock_phase,
   input  wire logic       lsb,
   input  wire logic [7:0] tx_byte,
   output logic      [7:0] rx_byte,
   output logic            miso
);
   logic [7:0] sh   = 8'h00;
   logic       last = 1'b0;
   logic       ss_q = 1'b1;
   logic       ck_q = 1'b0;

   // released line shows the inverse, so a stale bit never passes
   assign miso = ss_n ? ~last : last;

   // one process owns the shifter: select falling loads it, clock edges move it
   // edge leaving idle leads
   always @(sclk or ss_n)
   begin
      if (ss_q && !ss_n)
      begin
         sh = tx_byte;
         if (!clock_phase)
            last = lsb ? sh[0] : sh[7];
      end
      else if (!ss_n && sclk != ck_q)
      begin
         if ((sclk != clock_polarity) != clock_phase)
            rx_byte = lsb ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
         else
         begin
            if (clock_phase)
               last = lsb ? sh[0] : sh[7];
            sh = lsb ? (sh >> 1) : (sh << 1);
            if (!clock_phase)
               last = lsb ? sh[0] : sh[7];
         end
      end
      ss_q = ss_n;
      ck_q = sclk;
   end
endmodule : scc_far_slave

`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ns
`default_nettype none

module tb_top;
   import scc_pkg::*;
   logic              clk       = 1'b0;
   logic              arst_n    = 1'b0;
   logic [ADDR_W-1:0] addr      = '0;
   logic [7:0]        wr_data   = 8'h00;
   logic              wr_stb    = 1'b0;
   logic              rd_stb    = 1'b0;
   logic              wait_mode = 1'b0;
   logic              sclk_tb   = 1'b0;
   logic              mosi_tb   = 1'b0;
   logic              ss_tb     = 1'b1;
   logic              pcpol     = 1'b0;
   logic              pcpha     = 1'b0;
   logic              plsb      = 1'b0;
   logic [7:0]        ptx       = 8'h00;
   logic [7:0]        sb        = 8'hA5;
   logic [7:0]        rd_data;
   logic              irq;
   logic [7:0]        far_rx;
   logic              far_miso;
   logic              sclk_w;
   logic              mosi_w;
   logic              miso_w;
   logic              ss_w;
   scc_pins_in_type   pins_in;
   scc_pins_out_type  pins_out;
   logic [7:0]        s;
   logic [20:0]       pin_tab [9];
   int                miscompares = 0;
   int                n_checks    = 0;
   int                cyc         = 0;

   // undriven select line rests high through its pull-up
   assign ss_w    = pins_out.ss_oe ? pins_out.ss_o : ss_tb;
   assign sclk_w  = pins_out.sclk_oe ? pins_out.sclk_o : sclk_tb;
   assign mosi_w  = pins_out.mosi_oe ? pins_out.mosi_o : mosi_tb;
   assign miso_w  = pins_out.miso_oe ? pins_out.miso_o : far_miso;
   assign pins_in = {sclk_w, mosi_w, miso_w, ss_w};

   scc_spi_ctrl u_dut (.clk(clk), .arst_n(arst_n), .addr(addr), .wr_data(wr_data),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .pins_in(pins_in),
      .pins_out(pins_out), .wait_mode(wait_mode), .irq(irq));

   scc_far_slave u_far (.sclk(sclk_w), .mosi(mosi_w), .ss_n(ss_w), .clock_polarity(pcpol),
      .clock_phase(pcpha), .lsb(plsb), .tx_byte(ptx), .rx_byte(far_rx), .miso(far_miso));

   initial
   begin
      forever #50 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////
   task print_verdict;
   begin
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   end
   endtask : print_verdict

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 10000)
      begin
         miscompares++;
         print_verdict();
      end
   end

   task chk(input logic [7:0] got, input logic [7:0] exp);
   begin
      n_checks++;
      if (got !== exp)
      begin
         $display("Error t=%0t got %h exp %h", $time, got, exp);
         miscompares++;
      end
   end
   endtask : chk

   task wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
   begin
      @(posedge clk);
      addr    <= a;
      wr_data <= d;
      wr_stb  <= 1'b1;
      @(posedge clk);
      wr_stb  <= 1'b0;
   end
   endtask : wr

   task rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
   begin
      @(posedge clk);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      @(negedge clk);
      d = rd_data;
   end
   endtask : rd

   // bounded poll of the receive-full flag
   task wait_rx(output logic [7:0] st);
      bit got;
   begin
      got = 1'b0;
      for (int i = 0; i < 60 && !got; i++)
      begin
         rd(SCC_ADDR_STAT, st);
         got = (st[ST_RXF] === 1'b1);
      end
   end
   endtask : wait_rx

   function automatic logic [7:0] pin_oe();
      return {3'h0, pins_out.sclk_oe ? pins_out.sclk_o : 1'b0, pins_out.sclk_oe,
              pins_out.mosi_oe, pins_out.miso_oe, pins_out.ss_oe};
   endfunction : pin_oe

   // status must be read with tx empty before a data write counts
   task xfer(input logic [7:0] d, input logic [7:0] e);
   begin
      ptx = e;
      rd(SCC_ADDR_STAT, s);
      wr(SCC_ADDR_DATA, d);
      wait_rx(s);
      chk(s & 8'h80, 8'h80);
      rd(SCC_ADDR_DATA, s);
      chk(s, e);
      chk(far_rx, d);
   end
   endtask : xfer

   ////////////////////////////////////////////////////////////////////
   initial
   begin
      pin_tab = '{{8'h04, 8'h00, 5'h00}, {8'h50, 8'h00, 5'h0C}, {8'h58, 8'h00, 5'h1C},
                  {8'h52, 8'h00, 5'h0C}, {8'h52, 8'h18, 5'h0D}, {8'h50, 8'h10, 5'h0C},
                  {8'h50, 8'h01, 5'h08}, {8'h50, 8'h09, 5'h0C}, {8'h42, 8'h10, 5'h00}};
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      rd(SCC_ADDR_CTL1, s);
      chk(s, 8'h04);
      rd(SCC_ADDR_STAT, s);
      chk(s, 8'h20);
      chk({7'h00, irq}, 8'h00);
      wr(SCC_ADDR_CTL2, 8'hFF);
      rd(SCC_ADDR_CTL2, s);
      chk(s, 8'h1B);
      for (int i = 0; i < 9; i++)
      begin
         wr(SCC_ADDR_CTL2, pin_tab[i][12:5]);
         wr(SCC_ADDR_CTL1, pin_tab[i][20:13]);
         @(negedge clk);
         chk(pin_oe(), {3'h0, pin_tab[i][4:0]});
      end
      // slave: the bench plays master at the link clock rate
      wr(SCC_ADDR_CTL1, 8'hC6);
      ss_tb <= 1'b0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk(pin_oe(), 8'h02);
      for (int b = 7; b >= 0; b--)
      begin
         repeat (4) @(posedge clk);
         sclk_tb <= 1'b1;
         mosi_tb <= sb[b];
         repeat (4) @(posedge clk);
         sclk_tb <= 1'b0;
      end
      repeat (4) @(posedge clk);
      ss_tb <= 1'b1;
      wait_rx(s);
      @(negedge clk);
      chk({7'h00, irq}, 8'h01);
      rd(SCC_ADDR_DATA, s);
      chk(s, 8'hA5);
      @(negedge clk);
      chk({7'h00, irq}, 8'h00);
      // master with automatic select, clocks kept running in wait
      wr(SCC_ADDR_CTL2, 8'h18);
      wait_mode <= 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         {pcpol, pcpha, plsb} = i[2:0];
         wr(SCC_ADDR_CTL1, {4'b0101, i[2], i[1], 1'b1, i[0]});
         xfer(8'hC1 + 8'(i), 8'h2B ^ 8'(i));
      end
      // disable in mid-byte
      rd(SCC_ADDR_STAT, s);
      wr(SCC_ADDR_DATA, 8'h77);
      repeat (20) @(posedge clk);
      wr(SCC_ADDR_CTL1, 8'h1F);
      rd(SCC_ADDR_STAT, s);
      chk(s, 8'h20);
      chk(pin_oe(), 8'h00);
      wr(SCC_ADDR_CTL1, 8'h5F);
      repeat (120) @(posedge clk);
      rd(SCC_ADDR_STAT, s);
      chk(s, 8'h20);
      // wait-stop holds the byte until wait ends
      wr(SCC_ADDR_CTL2, 8'h1A);
      ptx = 8'h5A;
      rd(SCC_ADDR_STAT, s);
      wr(SCC_ADDR_DATA, 8'h3C);
      repeat (100) @(posedge clk);
      rd(SCC_ADDR_STAT, s);
      chk(s & 8'h80, 8'h00);
      @(posedge clk);
      wait_mode <= 1'b0;
      wait_rx(s);
      rd(SCC_ADDR_DATA, s);
      chk(s, 8'h5A);
      chk(far_rx, 8'h3C);
      // single wire, output on: the master hears its own byte on the shared line
      wr(SCC_ADDR_CTL2, 8'h19);
      xfer(8'h96, 8'h96);
      // mode fault through the select input
      wr(SCC_ADDR_CTL2, 8'h10);
      wr(SCC_ADDR_CTL1, 8'hD0);
      ss_tb <= 1'b0;
      repeat (6) @(posedge clk);
      rd(SCC_ADDR_STAT, s);
      chk(s, 8'h30);
      chk({7'h00, irq}, 8'h01);
      @(posedge clk);
      ss_tb <= 1'b1;
      // let the raised select pass the synchroniser so the clear is not beaten
      repeat (4) @(posedge clk);
      wr(SCC_ADDR_CTL1, 8'hD0);
      rd(SCC_ADDR_STAT, s);
      chk(s, 8'h20);
      chk({7'h00, irq}, 8'h00);
      wr(SCC_ADDR_CTL1, 8'hF0);
      @(negedge clk);
      chk({7'h00, irq}, 8'h01);
      wr(SCC_ADDR_CTL1, 8'hD0);
      @(negedge clk);
      chk({7'h00, irq}, 8'h00);
      print_verdict();
   end
endmodule : tb_top

`default_nettype wire
